// ==== inc/cvcm_pkg.sv ====
/*
 * cvcm_pkg: shared constants and carrier types for the channel value
 * combiner and threshold monitor block.
 * Assumes a 250 MHz system clock and signed two's complement values.
 */
package cvcm_pkg;

	// value format shared by channels, thresholds and the output
	localparam int VAL_W = 16;
	localparam logic signed [VAL_W-1:0] VAL_MAX = 16'sh7FFF;
	localparam logic signed [VAL_W-1:0] VAL_MIN = -16'sh7FFF - 16'sh0001;

	// index widths for channel and digital input selection
	localparam int CH_IDX_W = 3;
	localparam int DI_IDX_W = 3;

	// timing: one delay step, clock period, and the derived divider count
	localparam longint STEP_MS = 1;
	localparam longint CLK_PERIOD_PS = 4000;
	localparam longint PS_PER_MS = 64'd1_000_000_000;
	localparam int STEP_CYCLES = int'((STEP_MS * PS_PER_MS) / CLK_PERIOD_PS);
	localparam int DLY_W = 14;
	localparam logic [DLY_W-1:0] DLY_MAX_MS = 14'h2710; // 10000 ms

	// number of monitors and the error code they raise
	localparam int MON_N = 2;
	localparam logic [7:0] THR_ERR_CODE = 8'h0C; // E-12

	typedef enum logic [1:0]
	{
		CVCM_MON_OFF = 2'h0,
		CVCM_MON_ERR = 2'h1,
		CVCM_MON_STAT = 2'h2
	} cvcm_mon_type_t;

	typedef enum logic {CVCM_SEL_CMD = 1'b0, CVCM_SEL_FB = 1'b1} cvcm_sel_t;
	typedef enum logic {CVCM_FN_LT = 1'b0, CVCM_FN_GT = 1'b1} cvcm_fn_t;

	typedef struct packed
	{
		cvcm_mon_type_t mtype;
		cvcm_sel_t sel;
		cvcm_fn_t fn;
		logic signed [VAL_W-1:0] thresh;
		logic [DLY_W-1:0] delay_ms;
	} cvcm_mon_cfg_t;

	typedef enum logic [3:0]
	{
		CVCM_CB_PRIMARY = 4'h0,
		CVCM_CB_SECONDARY = 4'h1,
		CVCM_CB_ALT = 4'h2,
		CVCM_CB_ALT_INV = 4'h3,
		CVCM_CB_ALT_DIS = 4'h4,
		CVCM_CB_ALT_INV_DIS = 4'h5,
		CVCM_CB_MIN = 4'h6,
		CVCM_CB_MAX = 4'h7,
		CVCM_CB_OFFSET = 4'h8,
		CVCM_CB_OFFSET_BI = 4'h9
	} cvcm_cb_mode_t;

	typedef struct packed
	{
		cvcm_cb_mode_t mode;
		logic src_en;
		logic [CH_IDX_W-1:0] src_idx;
		logic di_en;
		logic [DI_IDX_W-1:0] di_idx;
	} cvcm_cb_cfg_t;

endpackage

// ==== verilog/cvcm_core.sv ====
/*
 * cvcm_core: two threshold monitors and the control value combiner of
 * one amplifier channel.
 * Assumes channel values, configuration and device state come from logic
 * on mclk; digital inputs are raw pins and are synchronised here.
 */
// Notes on behaviour
// - two independent monitors, identical settings each
// - type off: no compare, no flags
// - error mode sets threshold error output
// - status mode sets per-monitor status flag only
// - monitor watches command or feedback value
// - less-than or greater-than compare against threshold
// - 0 to 10000 ms delay, 1 ms steps
// - primary outputs own control value
// - secondary outputs source channel value
// - alternate: input active selects source, always
// - inverted alternate: input inactive selects source
// - disabled-only variants switch only while disabled
// - minimum mode outputs lower value
// - maximum mode outputs higher value
// - offset mode outputs own plus source
// - bidirectional offset adds away from zero
// - unassigned source uses no other channel
// - unassigned input: no digital input used
`timescale 1ns/1ns

module cvcm_core
	import cvcm_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int NUM_DI = 8,
	parameter int TICK_CYCLES = STEP_CYCLES
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire cvcm_mon_cfg_t mon_cfg [MON_N],
	input wire cvcm_cb_cfg_t cb_cfg,
	input wire logic signed [VAL_W-1:0] cmd_val,
	input wire logic signed [VAL_W-1:0] fb_val,
	input wire logic signed [VAL_W-1:0] own_val,
	input wire logic [NUM_CH-1:0][VAL_W-1:0] chan_val,
	input wire logic [NUM_DI-1:0] dig_in,
	input wire logic dev_active,
	output logic [MON_N-1:0] thr_stat_reg,
	output logic thr_err_reg,
	output logic [7:0] thr_err_code_reg,
	output logic signed [VAL_W-1:0] ctl_out_reg
);

	// the selection fields are fixed-width; refuse sizes they cannot reach
	if (NUM_CH < 1 || NUM_CH > (1 << CH_IDX_W))
		$error("cvcm_core: NUM_CH out of range");
	if (NUM_DI < 1 || NUM_DI > (1 << DI_IDX_W))
		$error("cvcm_core: NUM_DI out of range");
	if (TICK_CYCLES < 1)
		$error("cvcm_core: TICK_CYCLES must be at least one");

	////////////////////////////////////////////////////////////////////////
	// millisecond step enable

	logic [31:0] tick_cnt_reg;
	logic ms_tick_reg;
	wire tick_wrap = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

	// one-cycle enable every step; all monitors share it to save counters
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tick_cnt_reg <= 32'h0000_0000;
			ms_tick_reg <= 1'b0;
		end
		else
		begin
			tick_cnt_reg <= tick_wrap ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
			ms_tick_reg <= tick_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// threshold monitors

	logic [MON_N-1:0] mon_act_reg;
	logic [MON_N-1:0] mon_raw;
	logic [MON_N-1:0] mon_is_err;
	logic [MON_N-1:0] mon_is_stat;

	for (genvar g = 0; g < MON_N; g++)
	begin : g_mon
		logic [DLY_W-1:0] dly_cnt_reg;
		wire mon_off = (mon_cfg[g].mtype == CVCM_MON_OFF);
		// pick the watched signal, then compare in the chosen direction
		wire logic signed [VAL_W-1:0] watched =
			(mon_cfg[g].sel == CVCM_SEL_FB) ? fb_val : cmd_val;
		wire below = watched < mon_cfg[g].thresh;
		wire above = watched > mon_cfg[g].thresh;
		assign mon_raw[g] = !mon_off &&
			((mon_cfg[g].fn == CVCM_FN_LT) ? below : above);
		assign mon_is_err[g] = mon_cfg[g].mtype == CVCM_MON_ERR;
		assign mon_is_stat[g] = mon_cfg[g].mtype == CVCM_MON_STAT;
		// settings above the longest delay are served as the longest
		wire [DLY_W-1:0] dly_lim = (mon_cfg[g].delay_ms > DLY_MAX_MS) ?
			DLY_MAX_MS : mon_cfg[g].delay_ms;
		wire dly_done = dly_cnt_reg >= dly_lim;

		// the filtered flag follows the raw compare only after the delay;
		// any return to agreement drops the count so the wait restarts
		always_ff @(posedge mclk)
		begin
			if (rst || mon_off)
			begin
				mon_act_reg[g] <= 1'b0;
				dly_cnt_reg <= '0;
			end
			else if (mon_raw[g] == mon_act_reg[g])
				dly_cnt_reg <= '0;
			else if (dly_done)
			begin
				mon_act_reg[g] <= mon_raw[g];
				dly_cnt_reg <= '0;
			end
			else if (ms_tick_reg)
				dly_cnt_reg <= dly_cnt_reg + 1'b1;
		end
	end

	// route each flag by its type; status flags stay per monitor, error flags are ORed into one
	wire [MON_N-1:0] stat_next = mon_act_reg & mon_is_stat;
	wire err_next = |(mon_act_reg & mon_is_err);

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			thr_stat_reg <= '0;
			thr_err_reg <= 1'b0;
			thr_err_code_reg <= 8'h00;
		end
		else
		begin
			thr_stat_reg <= stat_next;
			thr_err_reg <= err_next;
			thr_err_code_reg <= err_next ? THR_ERR_CODE : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// digital input synchroniser

	logic [NUM_DI-1:0] di_meta_reg;
	logic [NUM_DI-1:0] di_sync_reg;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			di_meta_reg <= '0;
			di_sync_reg <= '0;
		end
		else
		begin
			di_meta_reg <= dig_in;
			di_sync_reg <= di_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control value combiner

	// an unassigned or absent source falls back to the own value
	wire src_ok = cb_cfg.src_en && (32'(cb_cfg.src_idx) < NUM_CH);
	wire logic signed [VAL_W-1:0] src_val =
		src_ok ? $signed(chan_val[cb_cfg.src_idx]) : own_val;
	wire di_ok = cb_cfg.di_en && (32'(cb_cfg.di_idx) < NUM_DI);
	wire di_act = di_ok && di_sync_reg[cb_cfg.di_idx];
	wire dis_mode = (cb_cfg.mode == CVCM_CB_ALT_DIS) ||
		(cb_cfg.mode == CVCM_CB_ALT_INV_DIS);
	wire inv_mode = (cb_cfg.mode == CVCM_CB_ALT_INV) ||
		(cb_cfg.mode == CVCM_CB_ALT_INV_DIS);
	wire want_src = inv_mode ? !di_act : di_act;

	// remembered choice for the disabled-only variants
	logic use_src_reg;
	wire use_src_next = (dis_mode && dev_active) ? use_src_reg : want_src;

	always_ff @(posedge mclk)
	begin
		if (rst)
			use_src_reg <= 1'b0;
		else
			use_src_reg <= use_src_next;
	end

	// sums are one bit wider and clamp rather than wrap
	// bounds kept signed: an unsigned concatenation in the compare would
	// make every negative sum look huge and clamp it to the top
	wire logic signed [VAL_W:0] sat_hi = {VAL_MAX[VAL_W-1], VAL_MAX};
	wire logic signed [VAL_W:0] sat_lo = {VAL_MIN[VAL_W-1], VAL_MIN};
	wire logic signed [VAL_W:0] src_dir = (own_val < 0) ?
		-{src_val[VAL_W-1], src_val} : {src_val[VAL_W-1], src_val};
	wire logic signed [VAL_W:0] sum_bi =
		{own_val[VAL_W-1], own_val} + src_dir;
	wire logic signed [VAL_W:0] own_x = {own_val[VAL_W-1], own_val};
	wire logic signed [VAL_W:0] src_x = {src_val[VAL_W-1], src_val};
	wire logic signed [VAL_W:0] sum_sel =
		(cb_cfg.mode == CVCM_CB_OFFSET_BI) ? sum_bi : own_x + src_x;
	wire logic signed [VAL_W-1:0] sum_sat =
		(sum_sel > sat_hi) ? VAL_MAX :
		(sum_sel < sat_lo) ? VAL_MIN :
		sum_sel[VAL_W-1:0];

	logic signed [VAL_W-1:0] ctl_next;

	always_comb
	begin
		case (cb_cfg.mode)
			CVCM_CB_PRIMARY: ctl_next = own_val;
			CVCM_CB_SECONDARY: ctl_next = src_val;
			CVCM_CB_ALT, CVCM_CB_ALT_INV:
				ctl_next = want_src ? src_val : own_val;
			CVCM_CB_ALT_DIS, CVCM_CB_ALT_INV_DIS:
				ctl_next = use_src_next ? src_val : own_val;
			CVCM_CB_MIN:
				ctl_next = (src_val < own_val) ? src_val : own_val;
			CVCM_CB_MAX:
				ctl_next = (src_val > own_val) ? src_val : own_val;
			CVCM_CB_OFFSET, CVCM_CB_OFFSET_BI:
				ctl_next = src_ok ? sum_sat : own_val;
			default: ctl_next = own_val;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			ctl_out_reg <= '0;
		else
			ctl_out_reg <= ctl_next;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_off_quiet;
		@(posedge mclk) disable iff (rst)
		(mon_cfg[0].mtype == CVCM_MON_OFF) [*2] |=> !thr_stat_reg[0];
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("monitor off but status set");

	property p_err_code;
		@(posedge mclk) disable iff (rst)
		thr_err_reg |-> thr_err_code_reg == 8'h0C;
	endproperty
	a_err_code: assert property (p_err_code)
		else $error("threshold error without code 12");

	property p_stat_only;
		@(posedge mclk) disable iff (rst)
		(mon_cfg[1].mtype == CVCM_MON_STAT) [*2] |=>
			thr_stat_reg[1] == $past(mon_act_reg[1]);
	endproperty
	a_stat_only: assert property (p_stat_only)
		else $error("status flag does not follow monitor");

	property p_zero_delay;
		@(posedge mclk) disable iff (rst)
		(mon_cfg[0].delay_ms == '0 && mon_cfg[0].mtype != CVCM_MON_OFF &&
			mon_raw[0] != mon_act_reg[0]) |=> mon_act_reg[0] == $past(mon_raw[0]);
	endproperty
	a_zero_delay: assert property (p_zero_delay)
		else $error("zero delay monitor did not follow at once");

	property p_no_early;
		@(posedge mclk) disable iff (rst)
		(mon_cfg[0].delay_ms != '0 && mon_raw[0] != mon_act_reg[0] &&
			g_mon[0].dly_cnt_reg == '0) |=> $stable(mon_act_reg[0]);
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("monitor flag changed before delay");

	property p_primary;
		@(posedge mclk) disable iff (rst)
		cb_cfg.mode == CVCM_CB_PRIMARY |=> ctl_out_reg == $past(own_val);
	endproperty
	a_primary: assert property (p_primary)
		else $error("primary output is not own value");

	property p_unassigned;
		@(posedge mclk) disable iff (rst)
		(!cb_cfg.src_en && cb_cfg.mode != CVCM_CB_PRIMARY) |=>
			ctl_out_reg == $past(own_val);
	endproperty
	a_unassigned: assert property (p_unassigned)
		else $error("unassigned source altered output");

	property p_hold_active;
		@(posedge mclk) disable iff (rst)
		(dis_mode && dev_active) |=> $stable(use_src_reg);
	endproperty
	a_hold_active: assert property (p_hold_active)
		else $error("source choice changed while active");

	property p_min;
		@(posedge mclk) disable iff (rst)
		cb_cfg.mode == CVCM_CB_MIN |=>
			ctl_out_reg <= $past(own_val) && ctl_out_reg <= $past(src_val);
	endproperty
	a_min: assert property (p_min)
		else $error("minimum mode picked the higher value");

	property p_max;
		@(posedge mclk) disable iff (rst)
		cb_cfg.mode == CVCM_CB_MAX |=>
			ctl_out_reg >= $past(own_val) && ctl_out_reg >= $past(src_val);
	endproperty
	a_max: assert property (p_max)
		else $error("maximum mode picked the lower value");

	property p_no_di;
		@(posedge mclk) disable iff (rst)
		(!cb_cfg.di_en && cb_cfg.mode == CVCM_CB_ALT) |=>
			ctl_out_reg == $past(own_val);
	endproperty
	a_no_di: assert property (p_no_di)
		else $error("unassigned input still switched source");

endmodule // cvcm_core

// ==== verif/cvcm_peer_model.sv ====
/*
 * cvcm_peer_model: stands in for the other amplifier channels and the
 * digital input pins that feed the combiner.
 * Assumes the bench calls the tasks between edges; every change lands
 * 1 ns after the next rising edge of mclk, like the bench's own inputs.
 */
`timescale 1ns/1ns

module cvcm_peer_model
	import cvcm_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int NUM_DI = 8
)
(
	input wire logic mclk,
	output logic [NUM_CH-1:0][VAL_W-1:0] chan_val,
	output logic [NUM_DI-1:0] dig_in
);
	////////////////////////////////////////////////////////////////////
	// pins idle low and other channels idle at zero until set
	initial
	begin
		chan_val = '0;
		dig_in = '0;
	end

	// changes stay off the sampling edge so the bench timing is known
	task automatic set_chan(input int idx, input logic [VAL_W-1:0] v);
		@(posedge mclk);
		#1;
		chan_val[idx] = v;
	endtask

	task automatic set_di(input int idx, input logic b);
		@(posedge mclk);
		#1;
		dig_in[idx] = b;
	endtask
endmodule // cvcm_peer_model

// ==== verif/channel_value_combine_monitor_tb_top.sv ====
/*
 * channel_value_combine_monitor_tb_top: self-checking bench for the
 * threshold monitors and the control value combiner.
 * Assumes cvcm_core with a shortened delay tick and the peer model.
 */
`timescale 1ns/1ns

module channel_value_combine_monitor_tb_top;
	import cvcm_pkg::*;
	localparam int TICK = 4;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	cvcm_mon_cfg_t mon_cfg [MON_N];
	cvcm_cb_cfg_t cb_cfg;
	logic signed [VAL_W-1:0] cmd_val, fb_val, own_val;
	logic [3:0][VAL_W-1:0] chan_val;
	logic [7:0] dig_in;
	logic dev_active = 1'b0;
	logic [MON_N-1:0] thr_stat_reg;
	logic thr_err_reg;
	logic [7:0] thr_err_code_reg;
	logic signed [VAL_W-1:0] ctl_out_reg;
	int fail_count = 0;
	int compares = 0;

	////////////////////////////////////////////////////////////////////
	// 4 ns clock
	always #2 mclk = ~mclk;

	cvcm_core #(.NUM_CH(4), .NUM_DI(8), .TICK_CYCLES(TICK)) u_cvcm_core (
		.mclk(mclk), .rst(rst), .mon_cfg(mon_cfg), .cb_cfg(cb_cfg),
		.cmd_val(cmd_val), .fb_val(fb_val), .own_val(own_val),
		.chan_val(chan_val), .dig_in(dig_in), .dev_active(dev_active),
		.thr_stat_reg(thr_stat_reg), .thr_err_reg(thr_err_reg),
		.thr_err_code_reg(thr_err_code_reg), .ctl_out_reg(ctl_out_reg));

	cvcm_peer_model #(.NUM_CH(4), .NUM_DI(8)) u_cvcm_peer_model (
		.mclk(mclk), .chan_val(chan_val), .dig_in(dig_in));

	////////////////////////////////////////////////////////////////////
	// shared helpers: inputs always move 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// monitor scenarios
	task automatic mon_basic;
		mon_cfg[0] = '{CVCM_MON_STAT, CVCM_SEL_CMD, CVCM_FN_LT, 16'h000a, 14'h0};
		cmd_val = 16'h0005;
		cyc(3);
		chk("stat", 16'h0001, 16'(thr_stat_reg));
		chk("err", 16'h0000, 16'(thr_err_reg));
		mon_cfg[0].mtype = CVCM_MON_OFF;
		cyc(3);
		chk("stat off", 16'h0000, 16'(thr_stat_reg));
	endtask

	task automatic mon_err;
		mon_cfg[1] = '{CVCM_MON_ERR, CVCM_SEL_FB, CVCM_FN_GT, 16'hfff0, 14'h0};
		cmd_val = 16'h8000;
		fb_val = 16'h0000;
		cyc(3);
		chk("err", 16'h0001, 16'(thr_err_reg));
		chk("code", 16'h000c, 16'(thr_err_code_reg));
		chk("stat", 16'h0000, 16'(thr_stat_reg));
		mon_cfg[1].sel = CVCM_SEL_CMD;
		cyc(3);
		chk("err cmd", 16'h0000, 16'(thr_err_reg));
		chk("code", 16'h0000, 16'(thr_err_code_reg));
		// both monitors in status mode, each with its own settings
		mon_cfg[0] = '{CVCM_MON_STAT, CVCM_SEL_FB, CVCM_FN_GT, 16'h0005, 14'h0};
		mon_cfg[1] = '{CVCM_MON_STAT, CVCM_SEL_CMD, CVCM_FN_LT, 16'h0000, 14'h0};
		cyc(3);
		chk("stat pair", 16'h0002, 16'(thr_stat_reg));
		fb_val = 16'h0010;
		cyc(3);
		chk("stat both", 16'h0003, 16'(thr_stat_reg));
		chk("err none", 16'h0000, 16'(thr_err_reg));
	endtask

	// reset in mid-run clears every output, then the block recovers
	task automatic reset_mid;
		own_val = 16'h0032;
		rst = 1'b1;
		cyc(2);
		chk("rst stat", 16'h0000, 16'(thr_stat_reg));
		chk("rst err", 16'h0000, 16'(thr_err_reg));
		chk("rst code", 16'h0000, 16'(thr_err_code_reg));
		chk("rst ctl", 16'h0000, ctl_out_reg);
		rst = 1'b0;
		cyc(3);
		chk("stat again", 16'h0003, 16'(thr_stat_reg));
		chk("ctl again", 16'h0032, ctl_out_reg);
		mon_cfg[1].mtype = CVCM_MON_OFF;
	endtask

	// delay of 2 ticks of 4 cycles: status lands 7 to 10 cycles later
	task automatic mon_delay;
		cmd_val = 16'h0064;
		mon_cfg[0] = '{CVCM_MON_STAT, CVCM_SEL_CMD, CVCM_FN_LT, 16'h000a, 14'h2};
		cyc(20);
		cmd_val = 16'h0005;
		cyc(6);
		chk("early set", 16'h0000, 16'(thr_stat_reg));
		cyc(10);
		chk("late set", 16'h0001, 16'(thr_stat_reg));
		cmd_val = 16'h0064;
		cyc(4);
		chk("glitch", 16'h0001, 16'(thr_stat_reg));
		cmd_val = 16'h0005;
		cyc(16);
		chk("restart", 16'h0001, 16'(thr_stat_reg));
		cmd_val = 16'h0064;
		cyc(6);
		chk("early clr", 16'h0001, 16'(thr_stat_reg));
		cyc(10);
		chk("late clr", 16'h0000, 16'(thr_stat_reg));
	endtask

	////////////////////////////////////////////////////////////////////
	// combiner scenarios; source is channel 2, input is pin 5
	task automatic comb(input cvcm_cb_mode_t m, input logic [15:0] exp);
		cb_cfg.mode = m;
		cyc(4);
		chk(m.name(), exp, ctl_out_reg);
	endtask

	task automatic comb_modes;
		cb_cfg = '{CVCM_CB_PRIMARY, 1'b1, 3'h2, 1'b1, 3'h5};
		own_val = 16'hffce;
		u_cvcm_peer_model.set_chan(2, 16'h000a);
		comb(CVCM_CB_PRIMARY, 16'hffce);
		comb(CVCM_CB_SECONDARY, 16'h000a);
		comb(CVCM_CB_MIN, 16'hffce);
		comb(CVCM_CB_MAX, 16'h000a);
		comb(CVCM_CB_OFFSET, 16'hffd8);
		comb(CVCM_CB_OFFSET_BI, 16'hffc4);
		own_val = 16'h0032;
		u_cvcm_peer_model.set_chan(2, 16'hfff6);
		comb(CVCM_CB_OFFSET_BI, 16'h0028);
		comb(CVCM_CB_MIN, 16'hfff6);
		// sums clamp at both ends instead of wrapping
		own_val = 16'h7000;
		u_cvcm_peer_model.set_chan(2, 16'h2000);
		comb(CVCM_CB_OFFSET, 16'h7fff);
		own_val = 16'h9000;
		comb(CVCM_CB_OFFSET_BI, 16'h8000);
		comb(CVCM_CB_OFFSET, 16'hb000);
		own_val = 16'h0032;
		u_cvcm_peer_model.set_chan(2, 16'hfff6);
	endtask

	task automatic comb_alt;
		comb(CVCM_CB_ALT, 16'h0032);
		comb(CVCM_CB_ALT_INV, 16'hfff6);
		u_cvcm_peer_model.set_di(5, 1'b1);
		dev_active = 1'b1;
		comb(CVCM_CB_ALT, 16'hfff6);
		comb(CVCM_CB_ALT_INV, 16'h0032);
		dev_active = 1'b0;
		comb(CVCM_CB_ALT_INV_DIS, 16'h0032);
		dev_active = 1'b1;
		u_cvcm_peer_model.set_di(5, 1'b0);
		comb(CVCM_CB_ALT_INV_DIS, 16'h0032);
		dev_active = 1'b0;
		comb(CVCM_CB_ALT_INV_DIS, 16'hfff6);
		comb(CVCM_CB_ALT_DIS, 16'h0032);
		dev_active = 1'b1;
		u_cvcm_peer_model.set_di(5, 1'b1);
		comb(CVCM_CB_ALT_DIS, 16'h0032);
		dev_active = 1'b0;
		comb(CVCM_CB_ALT_DIS, 16'hfff6);
		cb_cfg.di_en = 1'b0;
		comb(CVCM_CB_ALT, 16'h0032);
		comb(CVCM_CB_ALT_INV, 16'hfff6);
		cb_cfg.src_en = 1'b0;
		comb(CVCM_CB_SECONDARY, 16'h0032);
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence: idle inputs, 10 cycles of reset, then scenarios
	initial
	begin
		mon_cfg[0] = '{CVCM_MON_OFF, CVCM_SEL_CMD, CVCM_FN_LT, 16'h0000, 14'h0};
		mon_cfg[1] = mon_cfg[0];
		cb_cfg = '{CVCM_CB_PRIMARY, 1'b0, 3'h0, 1'b0, 3'h0};
		cmd_val = 16'h0000;
		fb_val = 16'h0000;
		own_val = 16'h0000;
		cyc(10);
		rst = 1'b0;
		cyc(1);
		mon_basic();
		mon_err();
		reset_mid();
		mon_delay();
		comb_modes();
		comb_alt();
		stop_test();
	end

	// watchdog: the scenarios need well under 1000 cycles
	initial
	begin
		#20000;
		fail_count++;
		stop_test();
	end
endmodule // channel_value_combine_monitor_tb_top
